// ==== tb/mpc_gate_pairs.sv ====
// Far-side model of the three gate driver transistor pairs.
// Assumes arm order a_top..c_bot, where a one switches a transistor on.
module mpc_gate_pairs (
    input wire logic sys_clk_i,
    input wire logic [5:0] arm_pre_i,
    output logic [2:0] both_on_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Flag a pair with both sides on: a supply short on a real bridge
    always_ff @(posedge sys_clk_i) begin
        for (int p = 0; p < 3; p++) begin
            both_on_o[p] <= arm_pre_i[2 * p] & arm_pre_i[2 * p + 1];
        end
    end
endmodule // mpc_gate_pairs

// ==== tb/mpc_pwm_mask_props.sv ====
// Checker for the PWM counter and mask stage, watching the top-level ports only.
// Assumes writes land at the strobe edge and arms follow their inputs by one cycle.
module mpc_pwm_mask_props
    import mpc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [5:0] decoded_steps_i,
    input wire logic brake_active_i,
    input wire logic protect_trig_i,
    input wire logic [2:0] pair_gpio_i,
    input wire logic [2:0] filtered_hall_i,
    input wire logic [7:0] rdata_o,
    input wire logic [5:0] arm_pre_o,
    input wire logic [2:0] wave_o,
    input wire logic duty_match_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mcf_r;
    logic [5:0] sme_r;
    logic [5:0] smd_r;
    logic quiet;
    // ==========================================================
    // Shadow mask registers, so arm checks know the mode
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mcf_r <= MPC_MCF_RST;
            sme_r <= MPC_MASK_RST;
            smd_r <= MPC_MASK_RST;
        end else if (wr_i) begin
            if (addr_i == MPC_MASK_CONFIG) mcf_r <= wdata_i;
            if (addr_i == MPC_SOFT_MASK_ENABLE) sme_r <= wdata_i[5:0];
            if (addr_i == MPC_SOFT_MASK_DATA) smd_r <= wdata_i[5:0];
        end
    end
    // Neither override active, so the mask path decides
    assign quiet = !brake_active_i && !protect_trig_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // ==========================================================
    // Assertions
    a_brake_arms: assert property (brake_active_i |=> arm_pre_o == 6'h15)
        else $error("brake pattern missing");
    a_protect_arms: assert property (protect_trig_i && !brake_active_i |=>
        arm_pre_o == ($past(mcf_r[MPC_MCF_PROT_BIT]) ? 6'h15 : 6'h00)) else $error("protect pattern wrong");
    a_wo_read_zero: assert property (rd_i && addr_i inside {[4'h2:4'h9]} |=> rdata_o == 8'h00)
        else $error("write-only byte read nonzero");
    a_counter_high: assert property (rd_i && addr_i == MPC_COUNTER_HIGH |=> rdata_o[7:2] == 6'h00)
        else $error("counter high byte upper bits set");
    a_status_gates: assert property (rd_i && addr_i == MPC_GATE_HALL_STATUS |=>
        rdata_o[7:3] == {2'b00, $past(arm_pre_o[5:3])}) else $error("status gate bits wrong");
    a_wave_off: assert property (wr_i && addr_i == MPC_PWM_CONTROL && !wdata_i[MPC_CTL_ON_BIT] |=>
        ##1 wave_o == 3'h0) else $error("wave alive with counter off");
    a_irq_pulse: assert property (duty_match_irq_o |=> !duty_match_irq_o)
        else $error("duty match pulse too long");
    a_hw_compl_pair: assert property (quiet && mcf_r[7:0] ==? 8'b0???_0101 && !pair_gpio_i[1]
        && decoded_steps_i[3:2] == 2'b01 |=> arm_pre_o[3] != arm_pre_o[2]) else $error("pair not complementary");
    a_noncompl_zero: assert property (quiet && mcf_r[7:0] ==? 8'b0???_1??0 && !pair_gpio_i[1]
        && decoded_steps_i[3:2] == 2'b01 |=> !arm_pre_o[3]) else $error("idle arm carries inverse wave");
    a_sw_both_high: assert property (quiet && mcf_r[MPC_MCF_METHOD_BIT] && !pair_gpio_i[2]
        && sme_r[5:4] == 2'b11 && smd_r[5:4] == 2'b11 |=> arm_pre_o[5:4] == 2'b00) else $error("pair both on");
endmodule // mpc_pwm_mask_props

bind mpc_pwm_mask mpc_pwm_mask_props mpc_pwm_mask_props_i (.sys_clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .decoded_steps_i, .brake_active_i, .protect_trig_i, .pair_gpio_i, .filtered_hall_i, .rdata_o,
    .arm_pre_o, .wave_o, .duty_match_irq_o);

// ==== tb/mpc_pwm_mask_tb.sv ====
// Testbench for the PWM counter and mask stage: register tasks and windowed counts.
// Assumes wave bit n is duty channel n and phase a, b use channels 0, 1.
module mpc_pwm_mask_tb
    import mpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic brake_active_i = 1'b0, protect_trig_i = 1'b0, duty_match_irq_o;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o;
    logic [5:0] decoded_steps_i = 6'h00, arm_pre_o;
    logic [2:0] filtered_hall_i = 3'h5, pair_gpio_i = 3'h0, wave_o, both_on;
    int err_total = 0, checks = 0, ci, cs;
    int cw [3];
    int ca [6];
    // ==========================================================
    // Design, far-side model and clock
    mpc_pwm_mask mpc_pwm_mask_i (.sys_clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .decoded_steps_i,
        .brake_active_i, .protect_trig_i, .pair_gpio_i, .filtered_hall_i, .rdata_o, .arm_pre_o, .wave_o,
        .duty_match_irq_o);
    mpc_gate_pairs mpc_gate_pairs_i (.sys_clk_i, .arm_pre_i(arm_pre_o), .both_on_o(both_on));
    always #25 sys_clk_i = ~sys_clk_i;
    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Strobe stays up until the next task's edge, so no double assignment
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 chk({8'h00, rdata_o}, {8'h00, e});
    endtask
    // Settle, then count high cycles; windows are whole periods so phase drops out
    task automatic run(input int n);
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (40) @(posedge sys_clk_i);
        cw = '{0, 0, 0};
        ca = '{0, 0, 0, 0, 0, 0};
        ci = 0;
        cs = 0;
        repeat (n) begin
            @(posedge sys_clk_i);
            #1;
            for (int i = 0; i < 6; i++) ca[i] += (arm_pre_o[i] === 1'b1);
            for (int i = 0; i < 3; i++) cw[i] += (wave_o[i] === 1'b1);
            ci += (duty_match_irq_o === 1'b1);
            cs += ((|both_on) === 1'b1);
        end
    endtask
    task automatic chk_w(input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] e2);
        chk(cw[0], e0);
        chk(cw[1], e1);
        chk(cw[2], e2);
    endtask
    task automatic chk_arms(input logic [5:0] e, input int n);
        for (int i = 0; i < 6; i++) chk(ca[i], e[i] ? n : 0);
    endtask
    // Expected top/bottom counts over 100 cycles for one phase
    task automatic hw_pair(input int top, input int bot, input logic [1:0] st, input int s, input int t,
        input int m, input int d);
        int p;
        int q;
        p = m ? d : 100;
        q = (t || !m) ? 0 : 100 - d;
        if (st == 2'b10 && s == 0) q = 0;
        if (st == 2'b10 && s == 0) p = 100;
        if (st == 2'b01 && s == 1) begin
            p = 100;
            q = 0;
        end
        chk(top, (st == 2'b10) ? p : q);
        chk(bot, (st == 2'b10) ? q : p);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        // Reset values; status holds the live nonzero hall input bits so it is skipped
        for (int a = 0; a < 16; a++) begin
            if (a != 13) rd(a[3:0], (a == 12) ? MPC_MCF_RST : 8'h00);
        end
        wr(MPC_SOFT_MASK_ENABLE, 8'hff);
        rd(MPC_SOFT_MASK_ENABLE, 8'h3f);
        wr(MPC_COUNTER_LOW, 8'h55);
        rd(MPC_COUNTER_LOW, 8'h00);
        wr(MPC_DUTY_SYNC_CONTROL, 8'hff);
        rd(MPC_DUTY_SYNC_CONTROL, 8'h07);
        rd(MPC_DUTY_SYNC_CONTROL, 8'h03);
        // Period nine, mirrored duty four, reload flag self-clears
        wr(MPC_PERIOD_HIGH, 8'h00);
        wr(MPC_PERIOD_LOW, 8'h09);
        wr(MPC_DUTY0_HIGH, 8'h00);
        wr(MPC_DUTY0_LOW, 8'h04);
        wr(MPC_PWM_CONTROL, 8'h09);
        rd(MPC_PWM_CONTROL, 8'h09);
        rd(MPC_PWM_CONTROL, 8'h08);
        run(100);
        chk_w(40, 40, 40);
        // Separate writes wait for reload; a lone high byte never commits
        wr(MPC_DUTY_SYNC_CONTROL, 8'h00);
        wr(MPC_DUTY2_HIGH, 8'h01);
        wr(MPC_DUTY1_LOW, 8'h08);
        run(100);
        chk_w(40, 40, 40);
        wr(MPC_PWM_CONTROL, 8'h09);
        run(100);
        chk_w(40, 80, 40);
        wr(MPC_DUTY_SYNC_CONTROL, 8'h02);
        wr(MPC_DUTY0_LOW, 8'h02);
        wr(MPC_DUTY_SYNC_CONTROL, 8'h06);
        rd(MPC_DUTY_SYNC_CONTROL, 8'h06);
        rd(MPC_DUTY_SYNC_CONTROL, 8'h02);
        run(100);
        chk_w(20, 80, 40);
        for (int k = 1; k < 4; k++) begin
            wr(MPC_PWM_CONTROL, {2'b00, k[1:0], 4'h8});
            run(100 << k);
            chk(cw[1], 80 << k);
        end
        wr(MPC_PWM_CONTROL, 8'h48);
        run(100);
        chk(cw[1], 80);
        // Center modes: one match each way per 18-cycle period
        for (int al = 2; al < 4; al++) begin
            for (int c = 0; c < 4; c++) begin
                wr(MPC_PWM_CONTROL, {al[1:0], 3'b001, c[1:0], 1'b0});
                run(180);
                chk(ci, (c == 3) ? 20 : ((c == 0) ? 0 : 10));
            end
        end
        wr(MPC_PWM_CONTROL, 8'h00);
        run(20);
        chk(cw[0] + cw[1] + cw[2], 0);
        // Hardware mask table over arm, style and modulation bits
        wr(MPC_PWM_CONTROL, 8'h08);
        decoded_steps_i <= 6'b10_01_11;
        for (int s = 0; s < 2; s++) begin
            for (int t = 0; t < 2; t++) begin
                for (int m = 0; m < 2; m++) begin
                    wr(MPC_MASK_CONFIG, {4'h0, t[0], m[0], 1'b0, s[0]});
                    run(100);
                    hw_pair(ca[5], ca[4], 2'b10, s, t, m, 20);
                    hw_pair(ca[3], ca[2], 2'b01, s, t, m, 80);
                    chk(ca[1] + ca[0] + cs, 0);
                end
            end
        end
        // Brake and protect overrides
        for (int b = 1; b < 4; b++) begin
            for (int f = 0; f < 2; f++) begin
                wr(MPC_MASK_CONFIG, {5'h00, 1'b1, f[0], 1'b0});
                brake_active_i <= b[0];
                protect_trig_i <= b[1];
                run(20);
                chk_arms((b[0] || f[0]) ? 6'h15 : 6'h00, 20);
            end
        end
        rd(MPC_GATE_HALL_STATUS, 8'h15);
        brake_active_i <= 1'b0;
        protect_trig_i <= 1'b0;
        // Software mask: pair a both high is forced off, style bit ignored
        wr(MPC_SOFT_MASK_DATA, 8'h36);
        for (int t = 0; t < 2; t++) begin
            wr(MPC_MASK_CONFIG, t ? 8'h8c : 8'h84);
            run(20);
            chk_arms(6'b00_01_10, 20);
        end
        // Pair a in general I/O use falls back to the hardware table
        pair_gpio_i <= 3'b100;
        run(20);
        chk_arms(6'b10_01_10, 20);
        stop_test();
    end
    // Watchdog well beyond the planned run length
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        stop_test();
    end
endmodule // mpc_pwm_mask_tb

// ==== verilog/mpc_pkg.sv ====
// Constants, register map and carrier types for the motor PWM counter and mask stage.
// Assumes a single 20 MHz clock and a plain byte-wide register port.
// Contract
// - Align codes 00/01 edge, 10 center variant one, 11 center variant two; the code runs 10 and 11 identically.
// - Counter clock divider codes 00..11 divide source by 1, 2, 4, 8.
// - Counter-on high runs counter; low stops it and switches wave off.
// - Center duty-match interrupt select: none, up only, down only, both.
// - Reload low blocks transfers; high loads period at underflow, then self-clears.
// - Sync update request with enable loads all three duties together, then clears.
// - Mirror enable copies channel zero duty writes into channels one and two.
// - Duty values are 10-bit write-only low/high bytes, reset zero.
// - Period value is 10-bit write-only low/high bytes, reset zero.
// - Live counter readable as low/high bytes, reset zero.
// - Arm select low modulates bottom arms, high modulates top arms.
// - Modulation enable low removes PWM from arms; resets high.
// - Complementary hardware mask truth table per phase.
// - Non-complementary table drives non-PWM arm zero instead of inverted wave.
// - Mask method low hardware, high software; software ignores pair style.
// - Software mask enable replaces channel wave with its mask level.
// - Pair both masked with both levels one forces both outputs zero.
// - Complementary pair: non-PWM channel cannot be masked high, outputs zero; the code zeroes it only while the wave channel is high.
// - Brake overrides all: tops zero, bottoms one.
// - Protect: state select low all zero, high tops zero bottoms one.
// - Status reads three gate levels and three filtered hall inputs.
// - Pair in general I/O use gets no mask effect; the code drops only the software mask and keeps the hardware table.
// - High byte goes to 2-bit buffer; low byte write commits both.
package mpc_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [3:0] MPC_PWM_CONTROL = 4'h0;
    localparam logic [3:0] MPC_DUTY_SYNC_CONTROL = 4'h1;
    localparam logic [3:0] MPC_DUTY0_LOW = 4'h2;
    localparam logic [3:0] MPC_DUTY0_HIGH = 4'h3;
    localparam logic [3:0] MPC_DUTY1_LOW = 4'h4;
    localparam logic [3:0] MPC_DUTY1_HIGH = 4'h5;
    localparam logic [3:0] MPC_DUTY2_LOW = 4'h6;
    localparam logic [3:0] MPC_DUTY2_HIGH = 4'h7;
    localparam logic [3:0] MPC_PERIOD_LOW = 4'h8;
    localparam logic [3:0] MPC_PERIOD_HIGH = 4'h9;
    localparam logic [3:0] MPC_COUNTER_LOW = 4'ha;
    localparam logic [3:0] MPC_COUNTER_HIGH = 4'hb;
    localparam logic [3:0] MPC_MASK_CONFIG = 4'hc;
    localparam logic [3:0] MPC_GATE_HALL_STATUS = 4'hd;
    localparam logic [3:0] MPC_SOFT_MASK_ENABLE = 4'he;
    localparam logic [3:0] MPC_SOFT_MASK_DATA = 4'hf;
    // ==========================================================
    // Field positions
    localparam int MPC_CTL_ALIGN_LSB = 6;
    localparam int MPC_CTL_DIV_LSB = 4;
    localparam int MPC_CTL_ON_BIT = 3;
    localparam int MPC_CTL_IRQ_LSB = 1;
    localparam int MPC_CTL_RELOAD_BIT = 0;
    localparam int MPC_SYNC_REQ_BIT = 2;
    localparam int MPC_SYNC_EN_BIT = 1;
    localparam int MPC_MIRROR_BIT = 0;
    localparam int MPC_MCF_METHOD_BIT = 7;
    localparam int MPC_MCF_STYLE_BIT = 3;
    localparam int MPC_MCF_MODEN_BIT = 2;
    localparam int MPC_MCF_PROT_BIT = 1;
    localparam int MPC_MCF_ARM_BIT = 0;
    // ==========================================================
    // Reset values
    localparam logic [7:0] MPC_CONTROL_RST = 8'h00;
    localparam logic [2:0] MPC_SYNC_RST = 3'h0;
    localparam logic [9:0] MPC_VALUE_RST = 10'h000;
    localparam logic [7:0] MPC_MCF_RST = 8'h04;
    localparam logic [5:0] MPC_MASK_RST = 6'h00;
    // ==========================================================
    // Types
    typedef struct packed {
        logic [1:0] align_mode_sel;
        logic [1:0] counter_clk_div;
        logic counter_on;
        logic [1:0] center_irq_sel;
        logic reload_enable;
    } mpc_ctrl_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mpc_bus_t;

    typedef enum logic [1:0] {
        MPC_DIR_UP = 2'b01,
        MPC_DIR_DOWN = 2'b10
    } mpc_dir_t;
endpackage

// ==== verilog/mpc_pwm_mask.sv ====
// Motor PWM counter, three duty comparators and six-arm mask stage.
// Assumes hall decode, protect detect and pin-mode bits come from outside on the
// same clock, except filtered hall inputs which are synchronised here.
module mpc_pwm_mask
    import mpc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [5:0] decoded_steps_i,
    input wire logic brake_active_i,
    input wire logic protect_trig_i,
    input wire logic [2:0] pair_gpio_i,
    input wire logic [2:0] filtered_hall_i,
    output logic [7:0] rdata_o,
    output logic [5:0] arm_pre_o,
    output logic [2:0] wave_o,
    output logic duty_match_irq_o
);
    // ==========================================================
    // Register state
    mpc_ctrl_t ctrl_r;
    logic [2:0] sync_r;
    logic [7:0] mcf_r;
    logic [5:0] mask_en_r;
    logic [5:0] mask_lvl_r;
    logic [1:0] hibuf_r [4];
    logic [9:0] duty_buf_r [3];
    logic [9:0] duty_act_r [3];
    logic [9:0] period_buf_r;
    logic [9:0] period_act_r;
    logic [9:0] cnt_r;
    logic [2:0] pre_r;
    mpc_dir_t dir_r;
    logic [2:0] hall_s1_r;
    logic [2:0] hall_s2_r;
    mpc_bus_t bus;
    logic tick;
    logic underflow;
    logic load_duty;
    logic [2:0] cmp_wave;
    logic [5:0] arm_nxt;
    logic [2:0] div_mask;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Index of duty channel for a low or high byte offset
    function automatic logic [1:0] duty_idx(input logic [3:0] a);
        return 2'((a - MPC_DUTY0_LOW) >> 1);
    endfunction

    // ==========================================================
    // Control registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_r <= mpc_ctrl_t'(MPC_CONTROL_RST);
        end else begin
            if (bus.wr && bus.addr == MPC_PWM_CONTROL) begin
                ctrl_r <= mpc_ctrl_t'(bus.wdata);
            end else if (ctrl_r.reload_enable && underflow) begin
                ctrl_r.reload_enable <= 1'b0;
            end
        end
    end

    // Sync control; a software set wins the race against the hardware clear
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_r <= MPC_SYNC_RST;
        end else begin
            if (bus.wr && bus.addr == MPC_DUTY_SYNC_CONTROL) begin
                sync_r <= bus.wdata[2:0];
            end else if (load_duty) begin
                sync_r[MPC_SYNC_REQ_BIT] <= 1'b0;
            end
        end
    end

    // Mask configuration and software mask registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mcf_r <= MPC_MCF_RST;
            mask_en_r <= MPC_MASK_RST;
            mask_lvl_r <= MPC_MASK_RST;
        end else if (bus.wr) begin
            if (bus.addr == MPC_MASK_CONFIG) begin
                mcf_r <= {bus.wdata[7], 3'h0, bus.wdata[3:0]};
            end
            if (bus.addr == MPC_SOFT_MASK_ENABLE) begin
                mask_en_r <= bus.wdata[5:0];
            end
            if (bus.addr == MPC_SOFT_MASK_DATA) begin
                mask_lvl_r <= bus.wdata[5:0];
            end
        end
    end

    // ==========================================================
    // Duty and period write path; high byte parks in a 2-bit buffer
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 4; i++) begin
                hibuf_r[i] <= 2'h0;
            end
            for (int i = 0; i < 3; i++) begin
                duty_buf_r[i] <= MPC_VALUE_RST;
            end
            period_buf_r <= MPC_VALUE_RST;
        end else if (bus.wr) begin
            if (bus.addr == MPC_PERIOD_HIGH) begin
                hibuf_r[3] <= bus.wdata[1:0];
            end else if (bus.addr == MPC_PERIOD_LOW) begin
                period_buf_r <= {hibuf_r[3], bus.wdata};
            end else if (bus.addr >= MPC_DUTY0_LOW && bus.addr <= MPC_DUTY2_HIGH) begin
                if (bus.addr[0]) begin
                    hibuf_r[duty_idx(bus.addr)] <= bus.wdata[1:0];
                end else if (duty_idx(bus.addr) == 2'd0 && sync_r[MPC_MIRROR_BIT]) begin
                    for (int i = 0; i < 3; i++) begin
                        duty_buf_r[i] <= {hibuf_r[0], bus.wdata};
                    end
                end else begin
                    duty_buf_r[duty_idx(bus.addr)] <= {hibuf_r[duty_idx(bus.addr)], bus.wdata};
                end
            end
        end
    end

    // ==========================================================
    // Prescaler; a tick every 1, 2, 4 or 8 clocks
    assign div_mask = 3'((4'h1 << ctrl_r.counter_clk_div) - 4'h1);
    assign tick = ctrl_r.counter_on && ((pre_r & div_mask) == div_mask);
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_r <= 3'h0;
        end else begin
            pre_r <= ctrl_r.counter_on ? pre_r + 3'h1 : 3'h0;
        end
    end

    // Underflow: end of a PWM cycle, back at zero
    always_comb begin
        if (ctrl_r.align_mode_sel[1]) begin
            underflow = tick && dir_r == MPC_DIR_DOWN && cnt_r <= 10'h001;
        end else begin
            underflow = tick && cnt_r >= period_act_r;
        end
    end
    // Duty loads at reload underflow, or at once on a sync request
    assign load_duty = (ctrl_r.reload_enable && underflow)
        || (sync_r[MPC_SYNC_EN_BIT] && sync_r[MPC_SYNC_REQ_BIT]);

    // Counter; stops in place while off
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= MPC_VALUE_RST;
            dir_r <= MPC_DIR_UP;
        end else if (tick) begin
            if (!ctrl_r.align_mode_sel[1]) begin
                cnt_r <= underflow ? 10'h000 : cnt_r + 10'h001;
                dir_r <= MPC_DIR_UP;
            end else begin
                case (dir_r)
                    MPC_DIR_UP: begin
                        if (cnt_r >= period_act_r) begin
                            dir_r <= MPC_DIR_DOWN;
                            cnt_r <= (cnt_r == 10'h000) ? cnt_r : cnt_r - 10'h001;
                        end else begin
                            cnt_r <= cnt_r + 10'h001;
                        end
                    end
                    MPC_DIR_DOWN: begin
                        if (cnt_r <= 10'h001) begin
                            dir_r <= MPC_DIR_UP;
                            cnt_r <= 10'h000;
                        end else begin
                            cnt_r <= cnt_r - 10'h001;
                        end
                    end
                    default: dir_r <= MPC_DIR_UP;
                endcase
            end
        end
    end

    // Active period and duties only move from the buffers when allowed
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            period_act_r <= MPC_VALUE_RST;
            for (int i = 0; i < 3; i++) begin
                duty_act_r[i] <= MPC_VALUE_RST;
            end
        end else begin
            if (ctrl_r.reload_enable && underflow) begin
                period_act_r <= period_buf_r;
            end
            if (load_duty) begin
                for (int i = 0; i < 3; i++) begin
                    duty_act_r[i] <= duty_buf_r[i];
                end
            end
        end
    end

    // Compare waves; all off when the counter is switched off
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cmp_wave[i] = ctrl_r.counter_on && (cnt_r < duty_act_r[i]);
        end
    end

    // ==========================================================
    // Mask stage, per phase: bit 2p+1 top, bit 2p bottom; phase a (p=2) runs on channel 0
    always_comb begin
        logic ht;
        logic hb;
        logic w;
        logic wb;
        logic comp;
        logic [1:0] pr;
        ht = 1'b0;
        hb = 1'b0;
        w = 1'b0;
        wb = 1'b0;
        comp = 1'b0;
        pr = 2'b00;
        arm_nxt = 6'h00;
        for (int p = 0; p < 3; p++) begin
            ht = decoded_steps_i[2*p+1];
            hb = decoded_steps_i[2*p];
            // Modulation disabled leaves the arm fully on
            w = mcf_r[MPC_MCF_MODEN_BIT] ? cmp_wave[2-p] : 1'b1;
            wb = mcf_r[MPC_MCF_MODEN_BIT] ? ~cmp_wave[2-p] : 1'b0;
            // Software mask ignores the style bit and keeps both waves available
            comp = mcf_r[MPC_MCF_METHOD_BIT] || !mcf_r[MPC_MCF_STYLE_BIT];
            pr = 2'b00;
            if (ht && !hb) begin
                pr = mcf_r[MPC_MCF_ARM_BIT] ? {w, comp & wb} : 2'b10;
            end else if (!ht && hb) begin
                pr = mcf_r[MPC_MCF_ARM_BIT] ? 2'b01 : {comp & wb, w};
            end
            if (mcf_r[MPC_MCF_METHOD_BIT] && !pair_gpio_i[p]) begin
                for (int k = 0; k < 2; k++) begin
                    if (mask_en_r[2*p+k]) begin
                        pr[k] = mask_lvl_r[2*p+k];
                    end
                end
                if (mask_en_r[2*p+1] && mask_en_r[2*p] && mask_lvl_r[2*p+1] && mask_lvl_r[2*p]) begin
                    pr = 2'b00;
                end
                // Complementary pair: masked-high non-wave channel drops low while the wave channel is high
                if (!mask_en_r[2*p+1] && mask_en_r[2*p] && pr[1] && mask_lvl_r[2*p]) begin
                    pr[0] = 1'b0;
                end
                if (mask_en_r[2*p+1] && !mask_en_r[2*p] && pr[0] && mask_lvl_r[2*p+1]) begin
                    pr[1] = 1'b0;
                end
            end
            if (protect_trig_i) begin
                pr = {1'b0, mcf_r[MPC_MCF_PROT_BIT]};
            end
            if (brake_active_i) begin
                pr = 2'b01;
            end
            arm_nxt[2*p+1 -: 2] = pr;
        end
    end

    // ==========================================================
    // Outputs, hall synchroniser and read port
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            arm_pre_o <= 6'h00;
            wave_o <= 3'h0;
            duty_match_irq_o <= 1'b0;
            hall_s1_r <= 3'h0;
            hall_s2_r <= 3'h0;
        end else begin
            arm_pre_o <= arm_nxt;
            wave_o <= cmp_wave;
            hall_s1_r <= filtered_hall_i;
            hall_s2_r <= hall_s1_r;
            // One-cycle pulse on a duty-0 match at the counting edge
            duty_match_irq_o <= tick && ctrl_r.align_mode_sel[1] && cnt_r == duty_act_r[0]
                && ((dir_r == MPC_DIR_UP && ctrl_r.center_irq_sel[0])
                || (dir_r == MPC_DIR_DOWN && ctrl_r.center_irq_sel[1]));
        end
    end

    // Write-only registers read zero; unmapped reads are impossible with 16 slots
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                MPC_PWM_CONTROL: rdata_o <= ctrl_r;
                MPC_DUTY_SYNC_CONTROL: rdata_o <= {5'h00, sync_r};
                MPC_COUNTER_LOW: rdata_o <= cnt_r[7:0];
                MPC_COUNTER_HIGH: rdata_o <= {6'h00, cnt_r[9:8]};
                MPC_MASK_CONFIG: rdata_o <= mcf_r;
                MPC_GATE_HALL_STATUS: rdata_o <= {2'h0, arm_pre_o[5], arm_pre_o[4], arm_pre_o[3], hall_s2_r};
                MPC_SOFT_MASK_ENABLE: rdata_o <= {2'h0, mask_en_r};
                MPC_SOFT_MASK_DATA: rdata_o <= {2'h0, mask_lvl_r};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule // mpc_pwm_mask
